/* dtp_pkg.sv */
// Purpose: Shared constants and types for the debug test access port
// Assumes: Test clock sampled by the 250 MHz system clock
// Notes: Instruction codes occupy the upper nibble of the instruction register
package dtp_pkg;
  localparam int unsigned IR_W = 16;
  localparam logic [15:0] IR_RESET_VAL = 16'hEFFD;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_CLAMP = 4'h2;
  localparam logic [3:0] OP_HIGHZ = 4'h3;
  localparam logic [3:0] OP_SAMPLE = 4'h4;
  localparam logic [3:0] OP_IDCODE = 4'hE;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [31:0] ID_VALUE = 32'h1234_5001; // Arbitrary value
  localparam int unsigned ID_W = 32;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } dtp_tap_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } dtp_link_s;
endpackage

/* dtp_sync.sv */
// Purpose: Two-flop synchroniser for the pin inputs of the test port
// Assumes: Inputs asynchronous to the system clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module dtp_sync #(
  parameter int unsigned W = 3
) (
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Async reset, low
  input wire logic [W-1:0] d_i, // Async inputs
  output logic [W-1:0] q_o // Synchronised outputs
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // Two flop chain
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule
`default_nettype wire

/* dtp_tap.sv */
// Purpose: Test access port with instruction, bypass and id paths
// Assumes: Test clock far slower than CLOCK_I, edges found by sampling
// Notes: Boundary cells live outside; their serial path enters here
`timescale 1ns/1ps
`default_nettype none
module dtp_tap (
  input wire logic CLOCK_I, // System clock 250 MHz
  input wire logic RST_B_I, // System reset, low
  input wire logic TCK_I, // Test clock pin
  input wire logic TMS_I, // Mode select pin
  input wire logic TDI_I, // Serial data in
  input wire logic TRST_B_I, // Test reset, low
  input wire logic POR_PIN_B_I, // Power-on reset pin, low
  input wire logic EMU_SEL_B_I, // Emulator mode select pin
  input wire logic BSR_TDO_I, // Boundary chain serial out
  output logic TDO_O, // Serial data out
  output logic TDO_OE_O, // TDO drive enable
  output logic EMU_MODE_O, // Emulator mode chosen
  output logic [15:0] IR_O, // Instruction register
  output logic BSR_SHIFT_O, // Boundary chain shift pulse
  output logic BSR_CAPTURE_O, // Boundary chain capture pulse
  output logic BSR_UPDATE_O // Boundary chain update pulse
);
  // ---------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ---------------------------------------------------------------
  dtp_pkg::dtp_link_s link_raw;
  dtp_pkg::dtp_link_s link;
  logic [2:0] link_q;
  logic por_b;
  logic emu_pin;
  logic tck_d_r;
  logic [2:0] vld_r;
  logic rst_n;
  logic rise;
  logic fall;

  assign link_raw = '{tck: TCK_I, tms: TMS_I, tdi: TDI_I};
  assign rst_n = RST_B_I & TRST_B_I;
  assign link = link_q;

  // Link pins through two flops
  dtp_sync #(.W(3)) u_link_sync (
    .clk_i(CLOCK_I),
    .rst_b_i(rst_n),
    .d_i(link_raw),
    .q_o(link_q)
  );

  // Power-on and mode pins through two flops
  dtp_sync #(.W(2)) u_por_sync (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .d_i({POR_PIN_B_I, EMU_SEL_B_I}),
    .q_o({por_b, emu_pin})
  );

  // Previous test clock level; edges held off until the chain is full
  // so a clock parked high during reset gives no false rise
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      tck_d_r <= 1'b0;
      vld_r <= '0;
    end else begin
      tck_d_r <= link.tck;
      vld_r <= {vld_r[1:0], 1'b1};
    end
  end
  assign rise = vld_r[2] & link.tck & ~tck_d_r;
  assign fall = vld_r[2] & ~link.tck & tck_d_r;

  // ---------------------------------------------------------------
  // Emulator mode strap
  // ---------------------------------------------------------------
  logic emu_r;
  logic emu_nxt;

  // Follow the inverted pin while power-on reset is asserted, then hold
  always_comb begin
    emu_nxt = emu_r;
    if (!por_b) begin
      emu_nxt = ~emu_pin;
    end
  end
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      emu_r <= 1'b0;
    end else begin
      emu_r <= emu_nxt;
    end
  end
  assign EMU_MODE_O = emu_r;

  // ---------------------------------------------------------------
  // TAP controller
  // ---------------------------------------------------------------
  dtp_pkg::dtp_tap_e st_r;
  dtp_pkg::dtp_tap_e st_nxt;

  // Standard sixteen state walk on test clock rise
  always_comb begin
    st_nxt = st_r;
    if (rise) begin
      case (st_r)
        dtp_pkg::TLR: st_nxt = link.tms ? dtp_pkg::TLR : dtp_pkg::RTI;
        dtp_pkg::RTI: st_nxt = link.tms ? dtp_pkg::SEL_DR : dtp_pkg::RTI;
        dtp_pkg::SEL_DR: st_nxt = link.tms ? dtp_pkg::SEL_IR : dtp_pkg::CAP_DR;
        dtp_pkg::CAP_DR: st_nxt = link.tms ? dtp_pkg::EX1_DR : dtp_pkg::SH_DR;
        dtp_pkg::SH_DR: st_nxt = link.tms ? dtp_pkg::EX1_DR : dtp_pkg::SH_DR;
        dtp_pkg::EX1_DR: st_nxt = link.tms ? dtp_pkg::UPD_DR : dtp_pkg::PA_DR;
        dtp_pkg::PA_DR: st_nxt = link.tms ? dtp_pkg::EX2_DR : dtp_pkg::PA_DR;
        dtp_pkg::EX2_DR: st_nxt = link.tms ? dtp_pkg::UPD_DR : dtp_pkg::SH_DR;
        dtp_pkg::UPD_DR: st_nxt = link.tms ? dtp_pkg::SEL_DR : dtp_pkg::RTI;
        dtp_pkg::SEL_IR: st_nxt = link.tms ? dtp_pkg::TLR : dtp_pkg::CAP_IR;
        dtp_pkg::CAP_IR: st_nxt = link.tms ? dtp_pkg::EX1_IR : dtp_pkg::SH_IR;
        dtp_pkg::SH_IR: st_nxt = link.tms ? dtp_pkg::EX1_IR : dtp_pkg::SH_IR;
        dtp_pkg::EX1_IR: st_nxt = link.tms ? dtp_pkg::UPD_IR : dtp_pkg::PA_IR;
        dtp_pkg::PA_IR: st_nxt = link.tms ? dtp_pkg::EX2_IR : dtp_pkg::PA_IR;
        dtp_pkg::EX2_IR: st_nxt = link.tms ? dtp_pkg::UPD_IR : dtp_pkg::SH_IR;
        dtp_pkg::UPD_IR: st_nxt = link.tms ? dtp_pkg::SEL_DR : dtp_pkg::RTI;
        default: st_nxt = dtp_pkg::TLR;
      endcase
    end
  end
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= dtp_pkg::TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Instruction, bypass and id shift paths
  // ---------------------------------------------------------------
  logic [7:0] irs_r;
  logic [7:0] irs_nxt;
  logic [15:0] ir_r;
  logic [15:0] ir_nxt;
  logic byp_r;
  logic byp_nxt;
  logic [31:0] ids_r;
  logic [31:0] ids_nxt;
  logic [3:0] op;

  assign op = ir_r[15:12];

  // Capture, shift and update on test clock rise
  always_comb begin
    irs_nxt = irs_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    ids_nxt = ids_r;
    if (rise) begin
      case (st_r)
        dtp_pkg::TLR: ir_nxt = dtp_pkg::IR_RESET_VAL;
        dtp_pkg::CAP_IR: irs_nxt = dtp_pkg::IR_RESET_VAL[15:8];
        dtp_pkg::SH_IR: irs_nxt = {link.tdi, irs_r[7:1]};
        dtp_pkg::UPD_IR: ir_nxt = {irs_r, dtp_pkg::IR_RESET_VAL[7:0]};
        dtp_pkg::CAP_DR: begin
          byp_nxt = 1'b0;
          ids_nxt = dtp_pkg::ID_VALUE;
        end
        dtp_pkg::SH_DR: begin
          byp_nxt = link.tdi;
          ids_nxt = {link.tdi, ids_r[31:1]};
        end
        default: ir_nxt = ir_r;
      endcase
    end
  end
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      irs_r <= '0;
      ir_r <= dtp_pkg::IR_RESET_VAL;
      byp_r <= 1'b0;
      ids_r <= '0;
    end else begin
      irs_r <= irs_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      ids_r <= ids_nxt;
    end
  end
  assign IR_O = ir_r;
  assign BSR_CAPTURE_O = rise && st_r == dtp_pkg::CAP_DR;
  assign BSR_SHIFT_O = rise && st_r == dtp_pkg::SH_DR;
  assign BSR_UPDATE_O = rise && st_r == dtp_pkg::UPD_DR;

  // ---------------------------------------------------------------
  // Serial output on test clock fall
  // ---------------------------------------------------------------
  logic tdo_r;
  logic tdo_nxt;
  logic oe_r;
  logic oe_nxt;
  logic dr_bit;
  logic bsr_sel;

  assign bsr_sel = op == dtp_pkg::OP_EXTEST || op == dtp_pkg::OP_SAMPLE;

  // Data path source picked by the loaded instruction
  always_comb begin
    if (op == dtp_pkg::OP_IDCODE) begin
      dr_bit = ids_r[0];
    end else if (bsr_sel) begin
      dr_bit = BSR_TDO_I;
    end else begin
      dr_bit = byp_r;
    end
  end

  // Drive only in shift states; boundary data goes out at once
  always_comb begin
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    if (fall) begin
      oe_nxt = st_r == dtp_pkg::SH_DR || st_r == dtp_pkg::SH_IR;
      tdo_nxt = st_r == dtp_pkg::SH_IR ? irs_r[0] : dr_bit;
    end else if (bsr_sel && st_r == dtp_pkg::SH_DR && oe_r) begin
      tdo_nxt = BSR_TDO_I;
    end
  end
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      tdo_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
    end
  end
  assign TDO_O = tdo_r;
  assign TDO_OE_O = oe_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_cap_clears_bypass: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    rise && st_r == dtp_pkg::CAP_DR |=> !byp_r)
    else $error("bypass not cleared in capture");
  a_tlr_loads_ir: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    rise && st_r == dtp_pkg::TLR |=> ir_r == dtp_pkg::IR_RESET_VAL)
    else $error("instruction not reset");
  a_oe_shift_only: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    fall && st_r != dtp_pkg::SH_DR && st_r != dtp_pkg::SH_IR
    |=> !TDO_OE_O)
    else $error("tdo driven outside shift");
  a_tms_hold_tlr: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    rise && link.tms && st_r == dtp_pkg::TLR |=> st_r == dtp_pkg::TLR)
    else $error("tap left reset with tms high");
  a_tms_enter_rti: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    rise && !link.tms && st_r == dtp_pkg::TLR |=> st_r == dtp_pkg::RTI)
    else $error("tap missed idle");
  a_bypass_out: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    fall && st_r == dtp_pkg::SH_DR && op == dtp_pkg::OP_BYPASS
    |=> TDO_O == $past(byp_r))
    else $error("bypass bit not on tdo");
  a_emu_strap: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    !por_b |=> EMU_MODE_O == !$past(emu_pin))
    else $error("emulator strap wrong");
  a_ir_shift: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    rise && st_r == dtp_pkg::SH_IR |=> irs_r[7] == $past(link.tdi))
    else $error("tdi not captured");
  a_trst_clear: assert property (@(posedge CLOCK_I)
    !TRST_B_I |-> st_r == dtp_pkg::TLR && !TDO_OE_O)
    else $error("test reset did not clear");
endmodule
`default_nettype wire

/* dtp_probe.sv */
// Purpose: Behavioural boundary-scan tester on the far side of the port
// Assumes: One link bit lasts 40 system clocks (160 ns period)
// Notes: Link clock stands still between bits; TDI inverts once released
`timescale 1ns/1ps
`default_nettype none
module dtp_probe (
  input wire logic clk_i, // System clock for pacing
  input wire logic tdo_i, // Serial data from the port
  output var dtp_pkg::dtp_link_s link_o // Test clock, mode and data
);
  // ----------------------------------------
  // Link start level
  // ----------------------------------------
  initial begin
    link_o = '0;
  end

  // One bit: drive after clock fall, sample just before rise
  task automatic xfer(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk_i);
    #1;
    link_o.tck = 1'b0;
    link_o.tms = tms;
    link_o.tdi = tdi;
    repeat (20) @(posedge clk_i);
    #1;
    tdo = tdo_i;
    link_o.tck = 1'b1;
    repeat (19) @(posedge clk_i);
    #1;
    link_o.tdi = ~tdi; // Held bit has run out
  endtask
endmodule
`default_nettype wire

/* dtp_tap_tb.sv */
// Purpose: Self-checking bench for the debug test access port
// Assumes: Probe model paces the link; fixed seed for random values
// Notes: Walks every opcode through the data path, then test resets
`timescale 1ns/1ps
`default_nettype none
module dtp_tap_tb;
  logic clk, rst_b, trst_b, por_b, emu_b, bsr_tdo, tdo, tdo_oe, emu_mode;
  logic cap, shf, upd, tdo_bit;
  logic [15:0] ir;
  logic [31:0] din, q;
  logic [3:0] op, nib;
  dtp_pkg::dtp_link_s link;
  int n_fail = 0;
  int checks = 0;
  int seed = 32'h0000_6dfc;
  int cyc = 0;
  int n_cap = 0;
  int n_shf = 0;
  int n_upd = 0;
  int p_cap, p_shf, p_upd;

  // Boundary strobes counted mid-cycle, where they are settled
  always @(negedge clk) begin
    if (cap) n_cap <= n_cap + 1;
    if (shf) n_shf <= n_shf + 1;
    if (upd) n_upd <= n_upd + 1;
  end

  // ----------------------------------------
  // Design and tester
  // ----------------------------------------
  dtp_tap i_dtp_tap (.CLOCK_I(clk), .RST_B_I(rst_b), .TCK_I(link.tck),
    .TMS_I(link.tms), .TDI_I(link.tdi), .TRST_B_I(trst_b),
    .POR_PIN_B_I(por_b), .EMU_SEL_B_I(emu_b), .BSR_TDO_I(bsr_tdo),
    .TDO_O(tdo), .TDO_OE_O(tdo_oe), .EMU_MODE_O(emu_mode), .IR_O(ir),
    .BSR_SHIFT_O(shf), .BSR_CAPTURE_O(cap), .BSR_UPDATE_O(upd));
  dtp_probe i_dtp_probe (.clk_i(clk), .tdo_i(tdo_oe ? tdo : 1'b1),
    .link_o(link));

  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Mode bits, first bit in bit 0, with random TDI
  task automatic walk(input logic [7:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      i_dtp_probe.xfer(s[i], 1'($random(seed)), tdo_bit);
    end
  endtask
  // Shift n bits, leaving the shift state on the last one
  task automatic scan(input int n, input logic [31:0] d,
                      output logic [31:0] r);
    logic b;
    r = '0;
    for (int i = 0; i < n; i++) begin
      i_dtp_probe.xfer(i == n - 1, d[i], b);
      r[i] = b;
      chk({31'h0, tdo_oe}, 32'h0000_0001);
    end
  endtask
  task automatic load_ir(input logic [3:0] o, input logic [3:0] lo);
    walk(8'h03, 4);
    scan(8, {24'h0, o, lo}, q);
    chk(q, 32'h0000_00ef);
    walk(8'h01, 2);
    chk({16'h0, ir}, {16'h0, o, lo, 8'hfd});
  endtask
  // Data path expected for an opcode
  function automatic logic [31:0] exp_dr(input logic [3:0] o,
      input logic [31:0] d, input logic b);
    if (o == dtp_pkg::OP_IDCODE) return dtp_pkg::ID_VALUE;
    if (o == dtp_pkg::OP_EXTEST || o == dtp_pkg::OP_SAMPLE) return {32{b}};
    return {d[30:0], 1'b0};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    trst_b = 1'b0;
    por_b = 1'b0;
    emu_b = 1'b0;
    bsr_tdo = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // Strap taken under power-on reset, test reset held low meanwhile
    for (int s = 0; s < 2; s++) begin
      por_b = 1'b0;
      emu_b = s[0];
      repeat (4) @(posedge clk);
      #1;
      por_b = 1'b1;
      @(posedge clk);
      #1;
      emu_b = 1'($random(seed));
      repeat (4) @(posedge clk);
      #1;
      chk({31'h0, emu_mode}, {31'h0, ~s[0]});
    end
    chk({31'h0, emu_mode}, 32'h0);
    trst_b = 1'b1;
    chk({16'h0, ir}, {16'h0, dtp_pkg::IR_RESET_VAL});
    chk({31'h0, tdo_oe}, 32'h0);
    walk(8'h00, 1);
    // Every opcode, then random ones, through the data path
    for (int k = 0; k < 18; k++) begin
      op = (k < 16) ? k[3:0] : 4'($random(seed));
      nib = 4'($random(seed));
      bsr_tdo = 1'($random(seed));
      din = $random(seed);
      p_cap = n_cap;
      p_shf = n_shf;
      p_upd = n_upd;
      load_ir(op, nib);
      walk(8'h01, 3);
      scan(32, din, q);
      walk(8'h01, 2);
      chk(q, exp_dr(op, din, bsr_tdo));
      chk(n_cap - p_cap, 32'h0000_0001);
      chk(n_shf - p_shf, 32'h0000_0020);
      chk(n_upd - p_upd, 32'h0000_0001);
      chk({31'h0, tdo_oe}, 32'h0);
    end
    // Test reset acts without the link clock
    load_ir(dtp_pkg::OP_BYPASS, 4'h0);
    @(posedge clk);
    #1;
    trst_b = 1'b0;
    #1;
    chk({16'h0, ir}, {16'h0, dtp_pkg::IR_RESET_VAL});
    @(posedge clk);
    #1;
    trst_b = 1'b1;
    walk(8'h00, 1);
    // Five ones on mode select return to reset state
    load_ir(dtp_pkg::OP_BYPASS, 4'h5);
    walk(8'h1f, 6);
    chk({16'h0, ir}, {16'h0, dtp_pkg::IR_RESET_VAL});
    wrap_up();
  end
endmodule
`default_nettype wire
